// ===== core/watchdog_pkg.sv
// Shared constants and types for the watchdog down-counter block
package watchdog_pkg;

    // System clock rate
    localparam int CLK_MHZ           = 200;
    // Typical reset pulse length in nanoseconds
    localparam int RST_PULSE_NS      = 500;
    // Reset pulse length in clock cycles, rounded down
    localparam int RST_PULSE_CYCLES  = (RST_PULSE_NS * CLK_MHZ) / 1000;
    // System clocks per counter decrement
    localparam int DECREMENT_PERIOD  = 3072;

    // Bus geometry
    localparam int ADDR_W            = 8;
    localparam int DATA_W            = 8;
    // Address of the watchdog count register
    localparam logic [7:0] WDG_ADDR  = 8'hD8;
    // Reset value of the watchdog count register
    localparam logic [7:0] WDG_RESET = 8'hFE;
    // Answer for an unmapped read
    localparam logic [7:0] RD_NONE   = 8'h00;

    // Field positions in the register
    localparam int ENABLE_POS        = 0;
    localparam int SOFT_RESET_POS    = 1;
    localparam int COUNT_LSB_POS     = 2;
    localparam int COUNT_W           = 6;
    localparam int TIMER_W           = 7;

    // Widths of internal counters
    localparam int PRE_W             = 12;
    localparam int PULSE_W           = 8;
    localparam int SYNC_W            = 3;

    // Power mode of the core as seen by the watchdog
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_WAIT,
        MODE_STOP
    } power_mode_t;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

    // Whole state of the watchdog
    typedef struct packed {
        logic [PRE_W-1:0]   pre_cnt;
        logic [TIMER_W-1:0] timer;
        logic               enable;
        logic               hw_opt;
        logic               ext_opt;
        logic               straps_taken;
        logic [PULSE_W-1:0] pulse_cnt;
        logic               pulsing;
        logic               reset_n;
        power_mode_t        mode;
        logic               wait_flag;     // Registered WAIT indication
        logic               stop_flag;     // Registered STOP indication
        logic [SYNC_W-1:0]  nmi_sync;
        logic               nmi_level;
        logic [DATA_W-1:0]  rd_data;
    } wdg_state_t;

endpackage : watchdog_pkg

// ===== core/watchdog_downcounter_reset.sv
// Watchdog down-counter with reset pulse generation and stop-mode arbitration
`timescale 1ns/1ps

module watchdog_downcounter_reset #(
    parameter int PRESCALE    = watchdog_pkg::DECREMENT_PERIOD,  // Clocks per decrement
    parameter int PULSE_LEN   = watchdog_pkg::RST_PULSE_CYCLES   // Reset pulse clocks
) (
    input  wire logic                            sys_clk_in,                        // System clock
    input  wire logic                            rst_n_in,                          // Async reset
    input  wire logic [watchdog_pkg::ADDR_W-1:0] addr_in,                           // Register address
    input  wire logic [watchdog_pkg::DATA_W-1:0] wr_data_in,                        // Write data
    input  wire logic                            wr_in,                             // Write strobe
    input  wire logic                            rd_in,                             // Read strobe
    input  wire logic                            hardware_activation_option_in,     // Strap
    input  wire logic                            external_stop_control_option_in,   // Strap
    input  wire logic                            nmi_pin_in,                        // NMI pin level
    input  wire logic                            stop_instr_in,                     // STOP executed
    input  wire logic                            wait_instr_in,                     // WAIT executed
    input  wire logic                            wake_in,                           // Interrupt wakes
    output logic      [watchdog_pkg::DATA_W-1:0] rd_data_out,                       // Read data
    output logic                                 reset_pin_n_out,                   // Reset pin drive
    output logic                                 reset_pin_oe_out,                  // Reset pin enable
    output logic                                 wait_mode_out,                     // Core in WAIT
    output logic                                 stop_mode_out                      // Core in STOP
);

    // Registered state and its next value
    watchdog_pkg::wdg_state_t state_reg;
    watchdog_pkg::wdg_state_t state_next;
    // Bus request bundle
    watchdog_pkg::bus_req_t   req;

    // Pack the bus request
    assign req = '{addr: addr_in, wdata: wr_data_in, wr: wr_in, rd: rd_in};

    // Register image from the counter: count bits reversed
    function automatic logic [7:0] pack_reg(input logic [watchdog_pkg::TIMER_W-1:0] t,
                                            input logic                           en);
        logic [7:0] r;
        r = watchdog_pkg::RD_NONE;
        for (int i = 0; i < watchdog_pkg::COUNT_W; i++)
        begin
            r[7 - i] = t[i];
        end
        r[watchdog_pkg::SOFT_RESET_POS] = t[watchdog_pkg::COUNT_W];
        r[watchdog_pkg::ENABLE_POS]     = en;
        return r;
    endfunction : pack_reg

    // Counter from a register image
    function automatic logic [watchdog_pkg::TIMER_W-1:0] unpack_reg(input logic [7:0] r);
        logic [watchdog_pkg::TIMER_W-1:0] t;
        t = '0;
        for (int i = 0; i < watchdog_pkg::COUNT_W; i++)
        begin
            t[i] = r[7 - i];
        end
        t[watchdog_pkg::COUNT_W] = r[watchdog_pkg::SOFT_RESET_POS];
        return t;
    endfunction : unpack_reg

    // Address match, used by both strobes
    function automatic logic hit(input logic [watchdog_pkg::ADDR_W-1:0] a);
        return a == watchdog_pkg::WDG_ADDR;
    endfunction : hit

    // Decrement tick from the prescaler
    logic tick;
    // Counter frozen while the core sleeps in STOP
    logic frozen;
    // Watchdog expiry condition
    logic expire;
    // Reset-time register image
    localparam logic [7:0] RST_IMG = watchdog_pkg::WDG_RESET;
    // Counter value at reset, a constant so the reset branch stays plain
    localparam logic [watchdog_pkg::TIMER_W-1:0] RST_TIMER = unpack_reg(RST_IMG);

    // Next-state logic
    always_comb
    begin
        state_next = state_reg;
        frozen     = (state_reg.mode == watchdog_pkg::MODE_STOP);
        tick       = !frozen && (state_reg.pre_cnt == watchdog_pkg::PRE_W'(PRESCALE - 1));
        expire     = state_reg.enable && !state_reg.timer[watchdog_pkg::COUNT_W];

        // NMI pin synchroniser; level moves once stages two and three agree
        state_next.nmi_sync = {state_reg.nmi_sync[1:0], nmi_pin_in};
        if (state_reg.nmi_sync[1] == state_reg.nmi_sync[2])
        begin
            state_next.nmi_level = state_reg.nmi_sync[2];
        end

        // Straps taken on the first edge after release, then held
        if (!state_reg.straps_taken)
        begin
            state_next.straps_taken = 1'b1;
            state_next.hw_opt       = hardware_activation_option_in;
            state_next.ext_opt      = external_stop_control_option_in;
            state_next.enable       = hardware_activation_option_in;
        end

        // Prescaler runs in RUN and WAIT; holds in STOP
        if (!frozen)
        begin
            state_next.pre_cnt = tick ? '0 : state_reg.pre_cnt + 1'b1;
        end

        // Decrement one step per period; wraps freely as a timer
        if (tick)
        begin
            state_next.timer = state_reg.timer - 1'b1;
        end

        // Register write overrides a coincident decrement
        if (req.wr && hit(req.addr) && !state_reg.pulsing)
        begin
            state_next.timer = unpack_reg(req.wdata);
            if (state_reg.hw_opt || !state_reg.straps_taken)
            begin
                state_next.enable = state_next.enable;
            end
            else
            begin
                // One-way enable: a zero write cannot deactivate
                state_next.enable = state_reg.enable | req.wdata[watchdog_pkg::ENABLE_POS];
            end
        end

        // Read data stands one cycle after the strobe
        state_next.rd_data = watchdog_pkg::RD_NONE;
        if (req.rd && hit(req.addr))
        begin
            state_next.rd_data = pack_reg(state_reg.timer, state_reg.enable);
        end

        // Power mode arbitration
        if (wake_in && state_reg.mode != watchdog_pkg::MODE_RUN)
        begin
            state_next.mode = watchdog_pkg::MODE_RUN;
        end
        else if (wait_instr_in && state_reg.mode == watchdog_pkg::MODE_RUN)
        begin
            state_next.mode = watchdog_pkg::MODE_WAIT;
        end
        else if (stop_instr_in && state_reg.mode == watchdog_pkg::MODE_RUN)
        begin
            if (!state_reg.enable)
            begin
                state_next.mode = watchdog_pkg::MODE_STOP;
            end
            else if (!state_reg.ext_opt || !state_reg.nmi_level)
            begin
                state_next.mode = watchdog_pkg::MODE_WAIT;
            end
            else
            begin
                state_next.mode = watchdog_pkg::MODE_STOP;
            end
        end

        // Reset pulse sequencing
        if (!state_reg.pulsing)
        begin
            if (expire && state_reg.straps_taken)
            begin
                state_next.pulsing   = 1'b1;
                state_next.reset_n   = 1'b0;
                state_next.pulse_cnt = '0;
            end
        end
        else if (state_reg.pulse_cnt == watchdog_pkg::PULSE_W'(PULSE_LEN - 1))
        begin
            // Pulse over: the device restarts, options stay as taken
            state_next.pulsing   = 1'b0;
            state_next.reset_n   = 1'b1;
            state_next.pulse_cnt = '0;
            state_next.pre_cnt   = '0;
            state_next.timer     = unpack_reg(RST_IMG);
            state_next.enable    = state_reg.hw_opt;
            state_next.mode      = watchdog_pkg::MODE_RUN;
        end
        else
        begin
            state_next.pulse_cnt = state_reg.pulse_cnt + 1'b1;
        end

        // Mode flags registered so the outputs come straight from flip-flops
        state_next.wait_flag = (state_next.mode == watchdog_pkg::MODE_WAIT);
        state_next.stop_flag = (state_next.mode == watchdog_pkg::MODE_STOP);
    end

    // State register; reset loads constants only
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg              <= '0;
            state_reg.timer        <= RST_TIMER;
            state_reg.enable       <= RST_IMG[watchdog_pkg::ENABLE_POS];
            state_reg.reset_n      <= 1'b1;
            state_reg.mode         <= watchdog_pkg::MODE_RUN;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign rd_data_out      = state_reg.rd_data;
    assign reset_pin_n_out  = state_reg.reset_n;
    assign reset_pin_oe_out = state_reg.pulsing;
    assign wait_mode_out    = state_reg.wait_flag;
    assign stop_mode_out    = state_reg.stop_flag;

    // Helper: register-bus write to the watchdog
    logic wr_hit;
    assign wr_hit = wr_in && hit(addr_in);

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Named steps of the reset sequence
    sequence s_expire;
        !state_reg.pulsing && state_reg.straps_taken && state_reg.enable && !state_reg.timer[6];
    endsequence
    sequence s_pulse_start;
        state_reg.pulsing && !reset_pin_n_out && reset_pin_oe_out;
    endsequence

    a_hw_enable_held: assert property (state_reg.straps_taken && state_reg.hw_opt |-> state_reg.enable)
        else $error("hardware option lost enable");
    a_enable_one_way: assert property (state_reg.straps_taken && state_reg.enable && !state_reg.pulsing
                                       |=> state_reg.enable)
        else $error("enable cleared without reset");
    a_decrement_tick: assert property (state_reg.mode != watchdog_pkg::MODE_STOP
                                       && state_reg.pre_cnt == 12'(PRESCALE - 1) && !wr_hit && !state_reg.pulsing
                                       |=> state_reg.timer == $past(state_reg.timer) - 7'h01)
        else $error("missed decrement");
    a_no_early_dec: assert property (state_reg.pre_cnt != 12'(PRESCALE - 1) && !wr_hit && !state_reg.pulsing
                                     |=> $stable(state_reg.timer))
        else $error("counter moved between ticks");
    a_expiry_pulse: assert property (s_expire |=> s_pulse_start)
        else $error("expiry did not start reset");
    a_pulse_length: assert property (s_expire ##1 s_pulse_start |-> !reset_pin_n_out [*8])
        else $error("reset pulse too short");
    a_soft_reset: assert property (wr_hit && !state_reg.pulsing && state_reg.enable && state_reg.straps_taken
                                   && !wr_data_in[1] |-> ##2 !reset_pin_n_out)
        else $error("soft reset not generated");
    a_timer_quiet: assert property (!state_reg.enable |-> ##1 reset_pin_n_out || $past(state_reg.pulsing))
        else $error("disabled timer caused reset");
    a_stop_frozen: assert property (stop_mode_out && !wr_hit |=> $stable(state_reg.timer)
                                    || !state_reg.pulsing && $past(state_reg.pulsing))
        else $error("counter ran in STOP");
    a_stop_as_wait: assert property (stop_instr_in && !wake_in && !wait_instr_in && !state_reg.pulsing
                                     && state_reg.mode == watchdog_pkg::MODE_RUN && state_reg.enable
                                     && !state_reg.ext_opt |=> wait_mode_out)
        else $error("STOP not turned into WAIT");
    a_read_image: assert property (rd_in && addr_in == watchdog_pkg::WDG_ADDR
                                   |=> rd_data_out[0] == $past(state_reg.enable))
        else $error("read image wrong");

endmodule : watchdog_downcounter_reset

// ===== testbench/watchdog_downcounter_reset_tb.sv
// Self-checking bench for the watchdog down-counter block
`timescale 1ns/1ps
module watchdog_downcounter_reset_tb;
    localparam int PS = 8;              // Shortened decrement period
    localparam int PL = 10;             // Shortened reset pulse
    logic       clk, rst_n, wr, rd;     // Clock, reset, strobes
    logic       hw, ext, nmi;           // Straps and NMI level
    logic       stp, wt, wk;            // Power-mode pulses
    logic [7:0] addr, wdata, rq;        // Bus lines
    logic       pin_n, oe, wmode, smode;// Observed outputs
    logic [7:0] lfsr, v, p, r;          // Random state and read values
    logic [6:0] t;                      // Timer value loaded
    int         n_fail, checked, cyc, n;

    watchdog_downcounter_reset #(.PRESCALE(PS), .PULSE_LEN(PL)) dut (
        .sys_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wr_data_in(wdata),
        .wr_in(wr), .rd_in(rd), .hardware_activation_option_in(hw),
        .external_stop_control_option_in(ext), .nmi_pin_in(nmi), .stop_instr_in(stp),
        .wait_instr_in(wt), .wake_in(wk), .rd_data_out(rq), .reset_pin_n_out(pin_n),
        .reset_pin_oe_out(oe), .wait_mode_out(wmode), .stop_mode_out(smode));

    // Free-running 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard: generous ceiling over the whole sequence
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end

    // Shift register source of random counts
    function logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction : rnd

    // Register image: count reversed in bits 7..2, soft-reset bit 1, enable bit 0
    function logic [7:0] enc(input logic [6:0] tv, input logic en);
        return {tv[0], tv[1], tv[2], tv[3], tv[4], tv[5], tv[6], en};
    endfunction : enc

    function logic [6:0] dec(input logic [7:0] b);
        return {b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
    endfunction : dec

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Prescaler phase is free, so one extra tick is tolerated
    task near(input string nm, input logic [6:0] e, input logic [7:0] g);
        chk(nm, {1'b0, (dec(g) === e - 7'h01) ? e - 7'h01 : e}, {1'b0, dec(g)});
    endtask : near

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe
    task rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rq;
    endtask : rd_reg

    // One-cycle pulse on stop (0), wait (1) or wake (2), then let the mode settle
    task kick(input int k);
        @(posedge clk);
        {stp, wt, wk} <= 3'h4 >> k;
        @(posedge clk);
        {stp, wt, wk} <= 3'h0;
        @(posedge clk);
        #1;
    endtask : kick

    task reset_dut(input logic h, input logic x);
        @(posedge clk);
        rst_n <= 1'b0; hw <= h; ext <= x;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : reset_dut

    // Wait bounded for the pin to drop, then measure the low time
    task expect_pulse(input int lim);
        int w;
        w = 0;
        n = 0;
        #1;
        while (pin_n !== 1'b0 && w < lim)
        begin
            @(posedge clk);
            #1 w++;
        end
        chk("pin_low", 8'h00, {7'h00, pin_n});
        chk("pin_oe", 8'h01, {7'h00, oe});
        while (pin_n === 1'b0 && n < 300)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk("pulse_len", PL[7:0], n[7:0]);
    endtask : expect_pulse

    task complete_run();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // Main sequence
    initial
    begin
        {rst_n, wr, rd, hw, ext, nmi, stp, wt, wk} = 9'h000;
        {addr, wdata} = 16'h0000;
        lfsr = 8'h58;
        {n_fail, checked, cyc} = 0;
        reset_dut(1'b0, 1'b0);
        rd_reg(8'hD8); chk("reset_image", 8'hFE, v);
        rd_reg(8'hD9); chk("unmapped", 8'h00, v);
        // Disabled counter as plain timer, first load wraps through zero
        for (int i = 0; i < 5; i++)
        begin
            r = rnd();
            t = (i == 0) ? 7'h01 : r[6:0];
            n = (i == 0) ? 3 : int'(r[1:0]) + 1;
            wr_reg(8'hD8, enc(t, 1'b0));
            repeat (PS * n) @(posedge clk);
            rd_reg(8'hD8); near("timer", t - n[6:0], v);
            chk("no_reset", 8'h01, {7'h00, pin_n});
        end
        $display("test timer done");
        // STOP with watchdog off freezes, wake resumes
        wr_reg(8'hD8, enc(7'h7F, 1'b0));
        kick(0); chk("stop_mode", 8'h01, {6'h00, wmode, smode});
        rd_reg(8'hD8); p = v;
        repeat (5 * PS) @(posedge clk);
        rd_reg(8'hD8); chk("frozen", p, v);
        kick(2); chk("woken", 8'h00, {6'h00, wmode, smode});
        repeat (2 * PS) @(posedge clk);
        rd_reg(8'hD8); near("resume", dec(p) - 7'h02, v);
        // WAIT keeps counting
        kick(1); chk("wait_mode", 8'h02, {6'h00, wmode, smode});
        rd_reg(8'hD8); p = v;
        repeat (2 * PS) @(posedge clk);
        rd_reg(8'hD8); near("wait_count", dec(p) - 7'h02, v);
        kick(2);
        $display("test power modes done");
        // Software enable cannot be withdrawn
        wr_reg(8'hD8, enc(7'h7F, 1'b1));
        wr_reg(8'hD8, enc(7'h7F, 1'b0));
        rd_reg(8'hD8); chk("enable_sticky", 8'h01, {7'h00, v[0]});
        kick(0); chk("stop_as_wait", 8'h02, {6'h00, wmode, smode});
        kick(2);
        // Expiry after three count steps: three ticks clear the soft-reset bit
        wr_reg(8'hD8, enc(7'h42, 1'b1));
        repeat (2 * PS - 2) @(posedge clk);
        #1 chk("early", 8'h01, {7'h00, pin_n});
        expect_pulse(3 * PS);
        rd_reg(8'hD8); chk("after_enable", 8'h00, {7'h00, v[0]});
        // Clearing the soft-reset bit while enabled
        wr_reg(8'hD8, enc(7'h7F, 1'b1));
        wr_reg(8'hD8, enc(7'h3F, 1'b1));
        expect_pulse(4);
        $display("test reset pulse done");
        // Hardware option with NMI steering STOP
        reset_dut(1'b1, 1'b1);
        rd_reg(8'hD8); chk("hw_enable", 8'h01, {7'h00, v[0]});
        wr_reg(8'hD8, enc(7'h7F, 1'b0));
        rd_reg(8'hD8); chk("hw_locked", 8'h01, {7'h00, v[0]});
        kick(0); chk("nmi_low", 8'h02, {6'h00, wmode, smode});
        kick(2);
        @(posedge clk);
        nmi <= 1'b1;
        repeat (8) @(posedge clk);
        kick(0); chk("nmi_high", 8'h01, {6'h00, wmode, smode});
        kick(2); chk("hw_wake", 8'h00, {6'h00, wmode, smode});
        $display("test hardware option done");
        complete_run();
    end
endmodule : watchdog_downcounter_reset_tb
